// [core/lhpm_persist.sv]
/*
  Consecutive-trigger filter: fires once the programmed number of
  triggering measurements has been seen in a row.
  Assumes sample is a one-cycle pulse per completed measurement.
*/
`timescale 1ns/1ns
module lhpm_persist (
  // Clock and reset
  input  wire logic     clk,
  input  wire logic     rst_n,
  // Sequencer side
  lhpm_persist_if.unit  p
);

  typedef struct packed {
    logic [lhpm_pkg::CNT_W-1:0] cnt;
    logic                       fire;
  } lhpm_persist_state_type;

  lhpm_persist_state_type s_reg;
  lhpm_persist_state_type s_next;
  logic [lhpm_pkg::CNT_W-1:0] inc;

  always_comb begin
    s_next      = s_reg;
    s_next.fire = 1'b0;
    inc = (s_reg.cnt == lhpm_pkg::PERSIST_16) ? s_reg.cnt : s_reg.cnt + 1'b1;
    if (p.clear) begin
      s_next.cnt = '0;
    end else if (p.sample) begin
      if (p.hit) begin
        s_next.cnt  = inc;
        s_next.fire = (inc >= lhpm_pkg::persist_count(p.sel));
      end else begin
        s_next.cnt = '0;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign p.fire = s_reg.fire;

endmodule

// [core/lhpm_persist_if.sv]
/*
  Link between the measurement sequencer and one persistence filter.
  Assumes both ends share the core clock.
*/
`timescale 1ns/1ns
interface lhpm_persist_if;
  logic       sample;
  logic       hit;
  logic       clear;
  logic [1:0] sel;
  logic       fire;

  modport seq  (output sample, output hit, output clear, output sel, input fire);
  modport unit (input sample, input hit, input clear, input sel, output fire);
endinterface

// [core/lhpm_pkg.sv]
/*
  Shared constants, register map, field layout and types of the
  light / proximity measurement and interrupt block.
  Assumes a 100 MHz core clock and a host on a plain register port.
*/
package lhpm_pkg;

  // ==========================================================
  // Widths
  localparam int ADDR_W     = 4;
  localparam int DATA_W     = 16;
  localparam int ALS_W      = 12;
  localparam int PROX_W     = 8;
  localparam int ALS_RAW_W  = 13;
  localparam int PROX_RAW_W = 9;
  localparam int TIMER_W    = 20;
  localparam int TICK_W     = 7;
  localparam int CNT_W      = 5;
  localparam int IRQ_W      = 3;

  // ==========================================================
  // Timing: 1 us tick derived from the clock period
  localparam int CLK_PERIOD_NS = 10;
  localparam int TICK_NS       = 1000;
  localparam int TICK_CYCLES   = TICK_NS / CLK_PERIOD_NS;
  localparam int US_PER_MS     = 1000;
  localparam int ALS_PERIOD_MS = 100;
  localparam int ALS_PERIOD_US = ALS_PERIOD_MS * US_PER_MS;
  localparam int PROX_CONV_US  = 540;
  localparam int LED_ON_US     = 100;
  localparam int SLEEP_MAX_MS  = 800;
  localparam int SLEEP_MAX_US  = SLEEP_MAX_MS * US_PER_MS;
  localparam logic [2:0] SLEEP_SEL_NONE = 3'h7;

  // ==========================================================
  // Full-scale codes
  localparam logic [ALS_W-1:0]  ALS_FULL  = 12'hFFF;
  localparam logic [PROX_W-1:0] PROX_FULL = 8'hFF;

  // ==========================================================
  // Register offsets
  localparam logic [ADDR_W-1:0] REG_CONFIG   = 4'h0;
  localparam logic [ADDR_W-1:0] REG_PERSIST  = 4'h1;
  localparam logic [ADDR_W-1:0] REG_ALS_LOW  = 4'h2;
  localparam logic [ADDR_W-1:0] REG_ALS_HIGH = 4'h3;
  localparam logic [ADDR_W-1:0] REG_PROX_THR = 4'h4;
  localparam logic [ADDR_W-1:0] REG_STATUS   = 4'h5;
  localparam logic [ADDR_W-1:0] REG_MASK     = 4'h6;
  localparam logic [ADDR_W-1:0] REG_ALS_DATA = 4'h7;
  localparam logic [ADDR_W-1:0] REG_PRX_DATA = 4'h8;
  localparam logic [ADDR_W-1:0] REG_STATE    = 4'h9;

  // ==========================================================
  // Field positions
  localparam int CFG_ALS_EN   = 0;
  localparam int CFG_PROX_EN  = 1;
  localparam int CFG_SLEEP    = 2;
  localparam int CFG_COMBINE  = 5;
  localparam int PERS_ALS     = 0;
  localparam int PERS_PROX    = 2;
  localparam int PERS_COMB    = 4;
  localparam int IRQ_ALS      = 0;
  localparam int IRQ_PROX     = 1;
  localparam int IRQ_COMB     = 2;
  localparam int ST_BUS_ID    = 0;
  localparam int ST_PWR_DOWN  = 1;
  localparam int ST_PHASE     = 2;
  localparam int ST_LED       = 4;

  // ==========================================================
  // Reset values
  localparam logic [ALS_W-1:0]  ALS_LOW_RST  = 12'h000;
  localparam logic [ALS_W-1:0]  ALS_HIGH_RST = 12'hFFF;
  localparam logic [PROX_W-1:0] PROX_THR_RST = 8'hFF;

  // ==========================================================
  // Persistence counts 1/4/8/16
  localparam logic [CNT_W-1:0] PERSIST_1  = 5'h01;
  localparam logic [CNT_W-1:0] PERSIST_4  = 5'h04;
  localparam logic [CNT_W-1:0] PERSIST_8  = 5'h08;
  localparam logic [CNT_W-1:0] PERSIST_16 = 5'h10;

  typedef enum logic [1:0] {
    PX_OFF   = 2'b00,
    PX_CONV  = 2'b01,
    PX_SLEEP = 2'b10
  } lhpm_prox_state_type;

  function automatic logic [CNT_W-1:0] persist_count(input logic [1:0] sel);
    case (sel)
      2'h0:    persist_count = PERSIST_1;
      2'h1:    persist_count = PERSIST_4;
      2'h2:    persist_count = PERSIST_8;
      default: persist_count = PERSIST_16;
    endcase
  endfunction

endpackage

// [core/lhpm_top.sv]
/*
  Measurement sequencing and interrupt logic of an ambient-light and
  proximity sensor: two independent conversion timers, LED pulse, window
  and threshold compare, persistence filters, interrupt status and pin.
  Assumes converter codes arrive asynchronously and are stable when
  sampled; the host reaches registers over a plain strobe port.
*/
// Design decisions made here: the strobed register port and the placing of the registers.
`timescale 1ns/1ns

// What this block does
// - Ambient and proximity conversions run on separate, independent sequencers.
// - One ambient conversion completes every 100 ms sample period.
// - Each proximity conversion lasts 540 us with the LED cycle inside it.
// - LED sink driven net 100 us per reading; sleep up to 800 ms between.
// - Ambient trigger when result is below low or above high threshold.
// - Proximity trigger when result exceeds the programmed threshold.
// - Interrupt only after 1, 4, 8 or 16 consecutive triggers.
// - Combined option needs both triggers together, up to 16 times in a row.
// - Interrupt shown on the pin and in readable status bits.
// - Interrupt pin is open-drain, pulled low when asserted.
// - Ambient results are 12-bit, saturating at 4095.
// - Proximity results are 8-bit, saturating at 255.
// - Both enables cleared stops all conversions and LED pulses.
module lhpm_top #(
  parameter int TICK_CYCLES   = lhpm_pkg::TICK_CYCLES,
  parameter int ALS_PERIOD_US = lhpm_pkg::ALS_PERIOD_US,
  parameter int PROX_CONV_US  = lhpm_pkg::PROX_CONV_US,
  parameter int LED_ON_US     = lhpm_pkg::LED_ON_US,
  parameter int SLEEP_MAX_US  = lhpm_pkg::SLEEP_MAX_US
) (
  // Clock and reset
  input  wire logic                                clk,
  input  wire logic                                rst_n,
  // Register port
  input  wire logic [lhpm_pkg::ADDR_W-1:0]         addr,
  input  wire logic [lhpm_pkg::DATA_W-1:0]         wr_data,
  input  wire logic                                wr_en,
  input  wire logic                                rd_en,
  output logic      [lhpm_pkg::DATA_W-1:0]         rd_data,
  // Converter codes from the analog front end
  input  wire logic [lhpm_pkg::ALS_RAW_W-1:0]      als_raw,
  input  wire logic [lhpm_pkg::PROX_RAW_W-1:0]     prox_raw,
  // Pins
  input  wire logic                                bus_id_select_pin,
  output logic                                     led_sink_drive,
  output logic                                     int_pin_o,
  output logic                                     int_pin_oe,
  output logic                                     irq
);

  localparam int TW = lhpm_pkg::TIMER_W;

  // ==========================================================
  // State
  typedef struct packed {
    logic                                 bus_id_s1;
    logic                                 bus_id_s2;
    logic [lhpm_pkg::ALS_RAW_W-1:0]       als_s1;
    logic [lhpm_pkg::ALS_RAW_W-1:0]       als_s2;
    logic [lhpm_pkg::PROX_RAW_W-1:0]      prox_s1;
    logic [lhpm_pkg::PROX_RAW_W-1:0]      prox_s2;
    logic [lhpm_pkg::TICK_W-1:0]          tick_cnt;
    logic                                 tick;
    logic [lhpm_pkg::DATA_W-1:0]          config_r;
    logic [lhpm_pkg::DATA_W-1:0]          persist_r;
    logic [lhpm_pkg::ALS_W-1:0]           als_low;
    logic [lhpm_pkg::ALS_W-1:0]           als_high;
    logic [lhpm_pkg::PROX_W-1:0]          prox_thr;
    logic [lhpm_pkg::IRQ_W-1:0]           status;
    logic [lhpm_pkg::IRQ_W-1:0]           mask;
    logic [TW-1:0]                        als_timer;
    logic [lhpm_pkg::ALS_W-1:0]           als_data;
    logic                                 als_done;
    logic                                 als_hit;
    lhpm_pkg::lhpm_prox_state_type        px_state;
    logic [TW-1:0]                        px_timer;
    logic [lhpm_pkg::PROX_W-1:0]          prox_data;
    logic                                 prox_done;
    logic                                 prox_hit;
    logic                                 led;
    logic [lhpm_pkg::DATA_W-1:0]          rd_data;
  } lhpm_top_state_type;

  lhpm_top_state_type s_reg;
  lhpm_top_state_type s_next;

  lhpm_persist_if als_pif ();
  lhpm_persist_if prox_pif ();
  lhpm_persist_if comb_pif ();

  logic                         als_en;
  logic                         prox_en;
  logic                         combine;
  logic [2:0]                   sleep_sel;
  logic [TW-1:0]                sleep_us;
  logic [lhpm_pkg::ALS_W-1:0]   als_code;
  logic [lhpm_pkg::PROX_W-1:0]  prox_code;
  logic [lhpm_pkg::IRQ_W-1:0]   irq_set;
  logic [lhpm_pkg::IRQ_W-1:0]   irq_clr;
  logic                         irq_any;

  // ==========================================================
  // Helpers
  function automatic logic wr_hit(input logic [lhpm_pkg::ADDR_W-1:0] a);
    wr_hit = wr_en && (addr == a);
  endfunction

  function automatic logic timer_end(input logic [TW-1:0] t, input int limit);
    timer_end = (t >= TW'(limit - 1));
  endfunction

  // ==========================================================
  // Control decode
  assign als_en    = s_reg.config_r[lhpm_pkg::CFG_ALS_EN];
  assign prox_en   = s_reg.config_r[lhpm_pkg::CFG_PROX_EN];
  assign combine   = s_reg.config_r[lhpm_pkg::CFG_COMBINE];
  assign sleep_sel = s_reg.config_r[lhpm_pkg::CFG_SLEEP +: 3];
  assign sleep_us  = (sleep_sel == lhpm_pkg::SLEEP_SEL_NONE) ? '0
                   : TW'(SLEEP_MAX_US) >> sleep_sel;

  // Saturating conversion codes
  assign als_code  = s_reg.als_s2[lhpm_pkg::ALS_W] ? lhpm_pkg::ALS_FULL
                   : s_reg.als_s2[lhpm_pkg::ALS_W-1:0];
  assign prox_code = s_reg.prox_s2[lhpm_pkg::PROX_W] ? lhpm_pkg::PROX_FULL
                   : s_reg.prox_s2[lhpm_pkg::PROX_W-1:0];

  // ==========================================================
  // Persistence filters
  assign als_pif.sample  = s_reg.als_done;
  assign als_pif.hit     = s_reg.als_hit;
  assign als_pif.clear   = !als_en;
  assign als_pif.sel     = s_reg.persist_r[lhpm_pkg::PERS_ALS +: 2];
  assign prox_pif.sample = s_reg.prox_done;
  assign prox_pif.hit    = s_reg.prox_hit;
  assign prox_pif.clear  = !prox_en;
  assign prox_pif.sel    = s_reg.persist_r[lhpm_pkg::PERS_PROX +: 2];
  // Combined evaluated per ambient result against latest proximity verdict
  assign comb_pif.sample = s_reg.als_done;
  assign comb_pif.hit    = s_reg.als_hit && s_reg.prox_hit;
  assign comb_pif.clear  = !(als_en && prox_en && combine);
  assign comb_pif.sel    = s_reg.persist_r[lhpm_pkg::PERS_COMB +: 2];

  lhpm_persist u_als_persist (
    .clk   (clk),
    .rst_n (rst_n),
    .p     (als_pif)
  );

  lhpm_persist u_prox_persist (
    .clk   (clk),
    .rst_n (rst_n),
    .p     (prox_pif)
  );

  lhpm_persist u_comb_persist (
    .clk   (clk),
    .rst_n (rst_n),
    .p     (comb_pif)
  );

  // ==========================================================
  // Interrupt sources
  always_comb begin
    irq_set = '0;
    if (combine) begin
      irq_set[lhpm_pkg::IRQ_COMB] = comb_pif.fire;
    end else begin
      irq_set[lhpm_pkg::IRQ_ALS]  = als_pif.fire;
      irq_set[lhpm_pkg::IRQ_PROX] = prox_pif.fire;
    end
    irq_clr = wr_hit(lhpm_pkg::REG_STATUS) ? wr_data[lhpm_pkg::IRQ_W-1:0] : '0;
  end

  // ==========================================================
  // Next state
  always_comb begin
    s_next = s_reg;

    // Input synchronisers
    s_next.bus_id_s1 = bus_id_select_pin;
    s_next.bus_id_s2 = s_reg.bus_id_s1;
    s_next.als_s1    = als_raw;
    s_next.als_s2    = s_reg.als_s1;
    s_next.prox_s1   = prox_raw;
    s_next.prox_s2   = s_reg.prox_s1;

    // Microsecond tick
    s_next.tick = 1'b0;
    if (s_reg.tick_cnt == lhpm_pkg::TICK_W'(TICK_CYCLES - 1)) begin
      s_next.tick_cnt = '0;
      s_next.tick     = 1'b1;
    end else begin
      s_next.tick_cnt = s_reg.tick_cnt + 1'b1;
    end

    // Register writes
    if (wr_hit(lhpm_pkg::REG_CONFIG)) begin
      s_next.config_r = wr_data;
    end
    if (wr_hit(lhpm_pkg::REG_PERSIST)) begin
      s_next.persist_r = wr_data;
    end
    if (wr_hit(lhpm_pkg::REG_ALS_LOW)) begin
      s_next.als_low = wr_data[lhpm_pkg::ALS_W-1:0];
    end
    if (wr_hit(lhpm_pkg::REG_ALS_HIGH)) begin
      s_next.als_high = wr_data[lhpm_pkg::ALS_W-1:0];
    end
    if (wr_hit(lhpm_pkg::REG_PROX_THR)) begin
      s_next.prox_thr = wr_data[lhpm_pkg::PROX_W-1:0];
    end
    if (wr_hit(lhpm_pkg::REG_MASK)) begin
      s_next.mask = wr_data[lhpm_pkg::IRQ_W-1:0];
    end
    // Sticky; a new event wins over a same-cycle clear
    s_next.status = (s_reg.status & ~irq_clr) | irq_set;

    // Ambient sequencer
    s_next.als_done = 1'b0;
    if (!als_en) begin
      s_next.als_timer = '0;
    end else if (s_reg.tick) begin
      if (timer_end(s_reg.als_timer, ALS_PERIOD_US)) begin
        s_next.als_timer = '0;
        s_next.als_data  = als_code;
        s_next.als_done  = 1'b1;
        s_next.als_hit   = (als_code < s_reg.als_low)
                        || (als_code > s_reg.als_high);
      end else begin
        s_next.als_timer = s_reg.als_timer + 1'b1;
      end
    end

    // Proximity sequencer
    s_next.prox_done = 1'b0;
    unique case (s_reg.px_state)
      lhpm_pkg::PX_OFF: begin
        s_next.px_timer = '0;
        if (prox_en) begin
          s_next.px_state = lhpm_pkg::PX_CONV;
        end
      end
      lhpm_pkg::PX_CONV: begin
        if (s_reg.tick) begin
          if (timer_end(s_reg.px_timer, PROX_CONV_US)) begin
            s_next.px_timer  = '0;
            s_next.px_state  = lhpm_pkg::PX_SLEEP;
            s_next.prox_data = prox_code;
            s_next.prox_done = 1'b1;
            s_next.prox_hit  = (prox_code > s_reg.prox_thr);
          end else begin
            s_next.px_timer = s_reg.px_timer + 1'b1;
          end
        end
      end
      lhpm_pkg::PX_SLEEP: begin
        if (s_reg.px_timer >= sleep_us) begin
          s_next.px_timer = '0;
          s_next.px_state = lhpm_pkg::PX_CONV;
        end else if (s_reg.tick) begin
          s_next.px_timer = s_reg.px_timer + 1'b1;
        end
      end
      default: begin
        s_next.px_state = lhpm_pkg::PX_OFF;
      end
    endcase
    if (!prox_en) begin
      s_next.px_state = lhpm_pkg::PX_OFF;
    end

    // LED on for the first part of each conversion
    s_next.led = (s_next.px_state == lhpm_pkg::PX_CONV)
              && (s_next.px_timer < TW'(LED_ON_US));

    // Register reads, data one cycle later
    s_next.rd_data = '0;
    if (rd_en) begin
      unique case (addr)
        lhpm_pkg::REG_CONFIG:   s_next.rd_data = s_reg.config_r;
        lhpm_pkg::REG_PERSIST:  s_next.rd_data = s_reg.persist_r;
        lhpm_pkg::REG_ALS_LOW:  s_next.rd_data = 16'(s_reg.als_low);
        lhpm_pkg::REG_ALS_HIGH: s_next.rd_data = 16'(s_reg.als_high);
        lhpm_pkg::REG_PROX_THR: s_next.rd_data = 16'(s_reg.prox_thr);
        lhpm_pkg::REG_STATUS:   s_next.rd_data = 16'(s_reg.status);
        lhpm_pkg::REG_MASK:     s_next.rd_data = 16'(s_reg.mask);
        lhpm_pkg::REG_ALS_DATA: s_next.rd_data = 16'(s_reg.als_data);
        lhpm_pkg::REG_PRX_DATA: s_next.rd_data = 16'(s_reg.prox_data);
        lhpm_pkg::REG_STATE: begin
          s_next.rd_data[lhpm_pkg::ST_BUS_ID]    = s_reg.bus_id_s2;
          s_next.rd_data[lhpm_pkg::ST_PWR_DOWN]  = !als_en && !prox_en;
          s_next.rd_data[lhpm_pkg::ST_PHASE +: 2] = s_reg.px_state;
          s_next.rd_data[lhpm_pkg::ST_LED]       = s_reg.led;
        end
        default:                s_next.rd_data = '0;
      endcase
    end
  end

  // ==========================================================
  // Registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_reg          <= '0;
      s_reg.als_low  <= lhpm_pkg::ALS_LOW_RST;
      s_reg.als_high <= lhpm_pkg::ALS_HIGH_RST;
      s_reg.prox_thr <= lhpm_pkg::PROX_THR_RST;
      s_reg.px_state <= lhpm_pkg::PX_OFF;
    end else begin
      s_reg <= s_next;
    end
  end

  // ==========================================================
  // Outputs
  assign irq_any        = |(s_reg.status & s_reg.mask);
  assign irq            = irq_any;
  assign int_pin_o      = 1'b0;
  assign int_pin_oe     = irq_any;
  assign led_sink_drive = s_reg.led;
  assign rd_data        = s_reg.rd_data;

endmodule

// [tb/lhpm_host_model.sv]
/*
  Host model: issues register writes and reads on the strobe port.
  Assumes the block's clock; released lines show inverted values.
*/
`timescale 1ns/1ns
module lhpm_host_model (
  // Clock
  input  wire logic                        clk,
  // Register port
  output logic      [lhpm_pkg::ADDR_W-1:0] addr,
  output logic      [lhpm_pkg::DATA_W-1:0] wr_data,
  output logic                             wr_en,
  output logic                             rd_en,
  input  wire logic [lhpm_pkg::DATA_W-1:0] rd_data
);
  initial begin
    addr    = 4'h0;
    wr_data = 16'h0000;
    wr_en   = 1'b0;
    rd_en   = 1'b0;
  end

  task automatic wr(input logic [3:0] a, input logic [15:0] v);
    @(posedge clk);
    wr_en   <= 1'b1;
    addr    <= a;
    wr_data <= v;
    @(posedge clk);
    wr_en   <= 1'b0;
    addr    <= ~a;
    wr_data <= ~v;
  endtask

  task automatic rd(input logic [3:0] a, output logic [15:0] v);
    @(posedge clk);
    rd_en <= 1'b1;
    addr  <= a;
    @(posedge clk);
    rd_en <= 1'b0;
    addr  <= ~a;
    @(negedge clk) v = rd_data;
    @(posedge clk);
  endtask
endmodule

// [tb/lhpm_properties.sv]
/*
  Port checker of the light / proximity measurement block.
  Assumes a bind to lhpm_top with the same scaled timing parameters.
*/
`timescale 1ns/1ns
module lhpm_properties #(
  parameter int TICK_CYCLES = 2,
  parameter int LED_ON_US   = 3
) (
  // Clock and reset
  input wire logic                        clk,
  input wire logic                        rst_n,
  // Register port
  input wire logic [lhpm_pkg::ADDR_W-1:0] addr,
  input wire logic [lhpm_pkg::DATA_W-1:0] wr_data,
  input wire logic                        wr_en,
  input wire logic                        rd_en,
  input wire logic [lhpm_pkg::DATA_W-1:0] rd_data,
  // Pins
  input wire logic                        led_sink_drive,
  input wire logic                        int_pin_o,
  input wire logic                        int_pin_oe,
  input wire logic                        irq
);
  localparam int LED_MAX = LED_ON_US * TICK_CYCLES;
  logic [7:0] led_run_reg;
  default clocking dc @(posedge clk); endclocking
  default disable iff (!rst_n);

  // ==========
  // Length of the current LED pulse
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      led_run_reg <= 8'h00;
    else if (led_sink_drive)
      led_run_reg <= led_run_reg + 8'h01;
    else
      led_run_reg <= 8'h00;
  end

  // ==========
  // Properties
  chk_od_data_low: assert property (int_pin_o == 1'b0)
    else $error("open-drain data not low");
  chk_irq_pin_same: assert property (irq == int_pin_oe)
    else $error("irq and pin enable differ");
  chk_led_pulse_len: assert property (led_sink_drive |-> int'(led_run_reg) <= LED_MAX)
    else $error("LED pulse too long");
  chk_irq_host_release: assert property ($fell(irq)
    |-> $past(wr_en) || $past(wr_en, 2)) else $error("irq dropped without a host write");
  chk_off_led_idle: assert property (wr_en && addr == lhpm_pkg::REG_CONFIG
    && wr_data[1:0] == 2'b00 |-> ##2 !led_sink_drive) else $error("LED on after power down");
  chk_rd_idle_zero: assert property (!rd_en |=> rd_data == 16'h0000)
    else $error("read data outside read slot");
  chk_status_upper: assert property (rd_en && addr == lhpm_pkg::REG_STATUS
    |=> rd_data[15:3] == 13'h0000) else $error("status upper bits set");
  chk_status_shows_irq: assert property (rd_en && addr == lhpm_pkg::REG_STATUS && irq
    |=> rd_data[2:0] != 3'h0) else $error("irq without status bit");
  chk_als_code_width: assert property (rd_en && addr == lhpm_pkg::REG_ALS_DATA
    |=> rd_data[15:12] == 4'h0) else $error("ambient code too wide");
  chk_prox_code_width: assert property (rd_en && addr == lhpm_pkg::REG_PRX_DATA
    |=> rd_data[15:8] == 8'h00) else $error("proximity code too wide");
  cov_irq_up: cover property ($rose(irq));
  cov_led_pulse: cover property ($fell(led_sink_drive));
  cov_status_seen: cover property (rd_en && addr == lhpm_pkg::REG_STATUS ##1 rd_data != 16'h0000);
endmodule

// [tb/tb.sv]
/*
  Self-checking bench of the light / proximity measurement block.
  Assumes lhpm_pkg, the block, host model and checker compile first.
*/
`timescale 1ns/1ns
module tb;
  // ==========
  // Scaled timing, stimulus rows
  localparam int TC  = 2;
  localparam int CNV = 10;
  localparam int LED = 3;
  localparam int SLP = 40;
  typedef struct packed {
    logic [15:0] cfg;
    logic [12:0] als;
    logic [8:0]  prx;
    logic [11:0] lo;
    logic [11:0] hi;
    logic [7:0]  thr;
    logic [2:0]  st;
  } lhpm_row_type;
  lhpm_row_type rows [8] = '{
    '{16'h001F, 13'h007F, 9'h021, 12'h080, 12'h200, 8'h20, 3'h3},
    '{16'h001F, 13'h0201, 9'h020, 12'h080, 12'h200, 8'h20, 3'h1},
    '{16'h001F, 13'h0080, 9'h020, 12'h080, 12'h080, 8'h1F, 3'h2},
    '{16'h001F, 13'h1000, 9'h100, 12'h000, 12'hFFE, 8'hFE, 3'h3},
    '{16'h003F, 13'h0201, 9'h021, 12'h080, 12'h200, 8'h20, 3'h4},
    '{16'h003F, 13'h0201, 9'h010, 12'h080, 12'h200, 8'h20, 3'h0},
    '{16'h0001, 13'h0201, 9'h021, 12'h080, 12'h200, 8'h20, 3'h1},
    '{16'h001E, 13'h0201, 9'h021, 12'h080, 12'h200, 8'h20, 3'h2}};
  int          pn [4] = '{1, 4, 8, 16};
  logic [2:0]  sel [5] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h7};
  logic [15:0] rv [7] = '{16'h0, 16'h0, 16'h0, 16'h0FFF, 16'h00FF, 16'h0, 16'h0};
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [12:0] als_raw = 13'h0000;
  logic [8:0]  prox_raw = 9'h000;
  logic        bus_id_select_pin = 1'b0;
  logic [3:0]  addr;
  logic [15:0] wr_data, rd_data, d;
  logic        wr_en, rd_en, led_sink_drive, int_pin_o, int_pin_oe, irq;
  int          error_cnt = 0;
  int          comparisons = 0;
  int          cycles = 0;
  int          hi, per, p, n;

  always #5 clk = ~clk;

  lhpm_top #(.TICK_CYCLES(TC), .ALS_PERIOD_US(20), .PROX_CONV_US(CNV),
    .LED_ON_US(LED), .SLEEP_MAX_US(SLP)) uut (.clk(clk), .rst_n(rst_n), .addr(addr),
    .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .als_raw(als_raw),
    .prox_raw(prox_raw), .bus_id_select_pin(bus_id_select_pin),
    .led_sink_drive(led_sink_drive), .int_pin_o(int_pin_o), .int_pin_oe(int_pin_oe), .irq(irq));
  lhpm_host_model host (.clk(clk), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
    .rd_en(rd_en), .rd_data(rd_data));

  // ==========
  // Compare, wait and closing tasks
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmp_rng(input int got, input int lo, input int up);
    comparisons++;
    if (got < lo || got > up) begin
      error_cnt++;
      $display("mismatch t=%0t got=%h exp=%h..%h", $time, got, lo, up);
    end
  endtask
  task automatic tk(input int c);
    repeat (c) @(posedge clk);
  endtask
  task automatic led_cycle(output int h, output int q);
    h = 0;
    while (!led_sink_drive) @(negedge clk);
    while (led_sink_drive) begin
      @(negedge clk);
      h++;
    end
    q = h;
    while (!led_sink_drive) begin
      @(negedge clk);
      q++;
    end
  endtask
  task automatic close_out();
    $display("comparisons=%0d error_cnt=%0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 30000) begin
      error_cnt++;
      close_out();
    end
  end

  // ==========
  // Main sequence
  initial begin
    tk(16);
    rst_n <= 1'b1;
    host.wr(lhpm_pkg::REG_MASK, 16'h0007);
    foreach (rows[i]) begin
      als_raw  <= rows[i].als;
      prox_raw <= rows[i].prx;
      host.wr(lhpm_pkg::REG_ALS_LOW, {4'h0, rows[i].lo});
      host.wr(lhpm_pkg::REG_ALS_HIGH, {4'h0, rows[i].hi});
      host.wr(lhpm_pkg::REG_PROX_THR, {8'h00, rows[i].thr});
      host.wr(lhpm_pkg::REG_CONFIG, rows[i].cfg);
      tk(100);
      host.wr(lhpm_pkg::REG_STATUS, 16'h0007);
      tk(100);
      host.rd(lhpm_pkg::REG_STATUS, d);
      cmp(d, {13'h0000, rows[i].st});
      cmp({15'h0000, irq}, {15'h0000, |rows[i].st});
      host.rd(lhpm_pkg::REG_ALS_DATA, d);
      if (rows[i].cfg[0])
        cmp(d, {4'h0, rows[i].als[12] ? 12'hFFF : rows[i].als[11:0]});
      host.rd(lhpm_pkg::REG_PRX_DATA, d);
      if (rows[i].cfg[1])
        cmp(d, {8'h00, rows[i].prx[8] ? 8'hFF : rows[i].prx[7:0]});
    end
    $display("row table done");
    @(posedge clk) rst_n <= 1'b0;
    tk(2);
    cmp({12'h000, led_sink_drive, irq, int_pin_oe, rd_data[0]}, 16'h0000);
    bus_id_select_pin <= 1'b1;
    @(posedge clk) rst_n <= 1'b1;
    foreach (rv[a]) begin
      host.rd(4'(a), d);
      cmp(d, rv[a]);
    end
    host.rd(lhpm_pkg::REG_STATE, d);
    cmp({14'h0000, d[1:0]}, 16'h0003);
    host.wr(4'hF, 16'hFFFF);
    host.rd(4'hF, d);
    cmp(d, 16'h0000);
    $display("reset test done");
    host.wr(lhpm_pkg::REG_ALS_LOW, 16'h0100);
    als_raw <= 13'h0010;
    foreach (pn[s]) begin
      host.wr(lhpm_pkg::REG_CONFIG, 16'h0000);
      host.wr(lhpm_pkg::REG_PERSIST, 16'(s));
      host.wr(lhpm_pkg::REG_STATUS, 16'h0007);
      host.wr(lhpm_pkg::REG_CONFIG, 16'h0001);
      tk(pn[s] * 40 - 20);
      host.rd(lhpm_pkg::REG_STATUS, d);
      cmp(d, 16'h0000);
      tk(40);
      host.rd(lhpm_pkg::REG_STATUS, d);
      cmp(d, 16'h0001);
      cmp({15'h0000, irq}, 16'h0000);
    end
    host.wr(lhpm_pkg::REG_MASK, 16'h0007);
    host.wr(lhpm_pkg::REG_CONFIG, 16'h0000);
    tk(50);
    cmp({15'h0000, irq}, 16'h0001);
    host.wr(lhpm_pkg::REG_STATUS, 16'h0001);
    tk(2);
    cmp({15'h0000, irq}, 16'h0000);
    $display("persistence test done");
    host.wr(lhpm_pkg::REG_PERSIST, 16'h0001);
    host.wr(lhpm_pkg::REG_CONFIG, 16'h0001);
    tk(100);
    als_raw <= 13'h0200;
    tk(40);
    als_raw <= 13'h0010;
    tk(120);
    host.rd(lhpm_pkg::REG_STATUS, d);
    cmp(d, 16'h0000);
    tk(40);
    host.rd(lhpm_pkg::REG_STATUS, d);
    cmp(d, 16'h0001);
    $display("restart test done");
    foreach (sel[s]) begin
      p = (CNV + (sel[s] == 3'h7 ? 0 : SLP >> sel[s])) * TC;
      host.wr(lhpm_pkg::REG_CONFIG, 16'h0000);
      host.wr(lhpm_pkg::REG_CONFIG, {11'h000, sel[s], 2'b10});
      led_cycle(hi, per);
      cmp_rng(hi, LED * TC - 1, LED * TC + 1);
      cmp_rng(per, p - 2, p + 3);
    end
    while (!led_sink_drive) @(negedge clk);
    host.wr(lhpm_pkg::REG_CONFIG, 16'h0000);
    tk(2);
    n = 0;
    repeat (200) begin
      @(negedge clk);
      n += int'(led_sink_drive);
    end
    cmp_rng(n, 0, 0);
    $display("led test done");
    close_out();
  end
endmodule

bind lhpm_top lhpm_properties #(.TICK_CYCLES(TICK_CYCLES), .LED_ON_US(LED_ON_US)) chk (
  .clk(clk), .rst_n(rst_n), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
  .rd_en(rd_en), .rd_data(rd_data), .led_sink_drive(led_sink_drive),
  .int_pin_o(int_pin_o), .int_pin_oe(int_pin_oe), .irq(irq));
